// ===== inc/dtmfhp_map.vh
// Purpose: Constants for the tone transceiver host port.
// Assumes: 40 MHz system clock.
// Notes: Definitions only.
`ifndef DTMFHP_MAP_VH
`define DTMFHP_MAP_VH

// Clock rate in hertz
`define DTMFHP_CLK_HZ 40000000
// Register select values
`define DTMFHP_SEL_DATA 1'b0
`define DTMFHP_SEL_CTRL 1'b1
// Control field positions
`define DTMFHP_CTL_TONE_EN 0
`define DTMFHP_CTL_IRQ_EN 1
`define DTMFHP_CTL_CP_MODE 2
`define DTMFHP_CTL_BURST 3
// Control reset value
`define DTMFHP_CTL_RESET 4'h0
// Status field positions
`define DTMFHP_ST_IRQ 0
`define DTMFHP_ST_TX_DONE 1
`define DTMFHP_ST_RX_FULL 2
`define DTMFHP_ST_DSTEER 3
// Receive code reset value
`define DTMFHP_RX_RESET 4'h0
// Burst and pause lengths in milliseconds
`define DTMFHP_BURST_MS 50
`define DTMFHP_PAUSE_MS 50
// Burst and pause lengths in cycles at 40 MHz, sized for the counter
`define DTMFHP_BURST_CYC 22'h1E8480
`define DTMFHP_PAUSE_CYC 22'h1E8480
// Settle delay before delayed steering, in cycles
`define DTMFHP_SETTLE_CYC 4'h3
// Burst counter width
`define DTMFHP_CNT_W 22

`endif

// ===== design/dtmfhp_burst.v
// Purpose: Burst timer: tone for one period, then a silent pause.
// Assumes: start is a one-cycle pulse; lengths are in clock cycles.
// Notes: A start while busy is ignored.
`timescale 1ns/100ps
`include "dtmfhp_map.vh"

module dtmfhp_burst #(
  parameter [`DTMFHP_CNT_W-1:0] TONE_CYC = 22'h1,
  parameter [`DTMFHP_CNT_W-1:0] PAUSE_CYC = 22'h1
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control
  input wire start,
  // Status
  output reg tone_on,
  output reg busy,
  output reg done
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_TONE = 2'h1;
  localparam [1:0] ST_PAUSE = 2'h2;

  reg [1:0] state; // Timer phase
  reg [`DTMFHP_CNT_W-1:0] count; // Cycles left in phase

  // Phase sequencing with precise counts
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      count <= {`DTMFHP_CNT_W{1'b0}};
      tone_on <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_TONE;
            count <= TONE_CYC - 22'h1;
            tone_on <= 1'b1;
            busy <= 1'b1;
          end
        end
        ST_TONE: begin
          if (count == {`DTMFHP_CNT_W{1'b0}}) begin
            state <= ST_PAUSE;
            count <= PAUSE_CYC - 22'h1;
            tone_on <= 1'b0;
          end else begin
            count <= count - 22'h1;
          end
        end
        ST_PAUSE: begin
          if (count == {`DTMFHP_CNT_W{1'b0}}) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            count <= count - 22'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          tone_on <= 1'b0;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule // dtmfhp_burst

// ===== design/dtmfhp_top.v
// Purpose: Digital side of a tone transceiver: host port, steering, request pin.
// Assumes: All inputs synchronous to clk; analog front end is outside.
// Notes: Two-way pins appear as in, out and output enable.
`timescale 1ns/100ps
`include "dtmfhp_map.vh"

// How it works
// - Data lines driven only on selected read
// - Register select decoded with read, write strobes
// - Interrupt mode: request low after tone event
// - Progress mode: request pin follows filtered input
// - Early detect rises on valid tone pair
// - Early detect falls on any signal loss
// - Steering high registers pair, updates latch
// - Steering low frees receiver for next pair
// - Guard output from early detect and steering
// - Burst mode times tone and pause internally
// - Progress filter selectable instead of decoding
// - Pair latched as four-bit receive code
// - Delayed steering holds request low, readable
// - Receive register read shows latched code
module dtmfhp_top #(
  parameter [`DTMFHP_CNT_W-1:0] BURST_CYC = `DTMFHP_BURST_CYC,
  parameter [`DTMFHP_CNT_W-1:0] PAUSE_CYC = `DTMFHP_PAUSE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Host strobes
  input wire chip_select_n,
  input wire read_n,
  input wire write_n,
  input wire register_select,
  // Host data bus, split
  input wire [3:0] host_data_in,
  output reg [3:0] host_data_out,
  output reg host_data_oe,
  // Tone detector results
  input wire tone_pair_valid,
  input wire [1:0] tone_low_index,
  input wire [1:0] tone_high_index,
  // Filtered call-progress comparator level
  input wire progress_level,
  // Steering and guard pin, split
  input wire steering_guard_in,
  output reg steering_guard_out,
  output reg steering_guard_oe,
  // Early detect
  output reg early_detect_out,
  // Open-drain request or progress pin
  output reg request_or_progress_out,
  output reg request_or_progress_oe,
  // Transmitter
  output reg tone_out_enable,
  output reg [3:0] tone_out_code
);

  // Tone pair to four-bit code
  function [3:0] pair_code;
    input [1:0] low;
    input [1:0] high;
    begin
      if (high == 2'h3) begin
        pair_code = (low == 2'h3) ? 4'h0 : (4'hD + {2'h0, low});
      end else if (low == 2'h3) begin
        case (high)
          2'h0: pair_code = 4'hB; // Star
          2'h1: pair_code = 4'hA; // Zero
          default: pair_code = 4'hC; // Hash
        endcase
      end else begin
        pair_code = {low, 2'h0} - {2'h0, low} + {2'h0, high} + 4'h1;
      end
    end
  endfunction

  reg [3:0] control; // Mode and enable bits
  reg [3:0] tx_code; // Code to send
  reg [3:0] rx_code; // Latched received code
  reg rx_full; // Unread code present
  reg tx_done; // Burst finished, sticky
  reg dsteer; // Delayed steering flag
  reg [3:0] settle; // Settle countdown
  reg steer_prev; // Steering level last cycle
  reg write_prev_n; // Write strobe last cycle
  reg read_prev_sel; // Select during last read cycle
  reg read_prev_rs; // Register select during last read
  reg burst_start; // Burst launch pulse
  wire burst_tone; // Burst tone phase
  wire burst_busy; // Burst in progress
  wire burst_done; // Burst finished pulse
  wire write_edge; // Write strobe release while selected
  wire read_end; // Selected read just finished
  wire cp_mode; // Call-progress mode
  wire steer_rise; // Steering crossed upward
  wire irq_level; // Request condition

  // Strobes act only while selected
  assign write_edge = ~chip_select_n & write_n & ~write_prev_n;
  assign read_end = read_prev_sel & (read_n | chip_select_n);
  assign cp_mode = control[`DTMFHP_CTL_CP_MODE];
  assign steer_rise = steering_guard_in & ~steer_prev;
  assign irq_level = dsteer | tx_done;

  // Burst timer
  dtmfhp_burst #(
    .TONE_CYC(BURST_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_burst (
    .clk(clk),
    .reset_n(reset_n),
    .start(burst_start),
    .tone_on(burst_tone),
    .busy(burst_busy),
    .done(burst_done)
  );

  // Strobe history
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_prev_n <= 1'b1;
      read_prev_sel <= 1'b0;
      read_prev_rs <= 1'b0;
      steer_prev <= 1'b0;
    end else begin
      write_prev_n <= write_n | chip_select_n;
      read_prev_sel <= ~chip_select_n & ~read_n;
      read_prev_rs <= register_select;
      steer_prev <= steering_guard_in;
    end
  end

  // Host writes: select picks transmit code or control
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= `DTMFHP_CTL_RESET;
      tx_code <= 4'h0;
      burst_start <= 1'b0;
    end else begin
      burst_start <= 1'b0;
      if (write_edge) begin
        if (register_select == `DTMFHP_SEL_CTRL) begin
          control <= host_data_in;
        end else begin
          tx_code <= host_data_in;
          // Burst mode launches timed tone on a code write while no burst is running
          burst_start <= control[`DTMFHP_CTL_BURST] & ~burst_busy;
        end
      end
    end
  end

  // Host read data and enable, registered
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_data_out <= 4'h0;
      host_data_oe <= 1'b0;
    end else begin
      host_data_oe <= ~chip_select_n & ~read_n;
      if (register_select == `DTMFHP_SEL_DATA) begin
        host_data_out <= rx_code;
      end else begin
        host_data_out <= {dsteer, rx_full, tx_done, irq_level};
      end
    end
  end

  // Early detect, guard output, registration
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      early_detect_out <= 1'b0;
      steering_guard_out <= 1'b0;
      steering_guard_oe <= 1'b0;
      rx_code <= `DTMFHP_RX_RESET;
    end else begin
      // Decoding inhibited while progress filter selected
      early_detect_out <= tone_pair_valid & ~cp_mode;
      // Drive toward early detect once steering agrees with it
      steering_guard_out <= early_detect_out;
      steering_guard_oe <= ~(early_detect_out ^ steering_guard_in);
      if (steer_rise & ~cp_mode) begin
        rx_code <= pair_code(tone_low_index, tone_high_index);
      end
    end
  end

  // Delayed steering after settle, cleared by steering low
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dsteer <= 1'b0;
      settle <= 4'h0;
      rx_full <= 1'b0;
    end else begin
      if (!steering_guard_in) begin
        dsteer <= 1'b0;
        settle <= 4'h0;
      end else if (steer_rise & ~cp_mode) begin
        settle <= `DTMFHP_SETTLE_CYC;
      end else if (settle == 4'h1) begin
        dsteer <= 1'b1;
        settle <= 4'h0;
      end else if (settle != 4'h0) begin
        settle <= settle - 4'h1;
      end
      // New code sets, data read clears; set wins
      if (settle == 4'h1 && steering_guard_in) begin
        rx_full <= 1'b1;
      end else if (read_end & (read_prev_rs == `DTMFHP_SEL_DATA)) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Transmit done flag: burst end sets, status read clears
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_done <= 1'b0;
    end else if (burst_done) begin
      tx_done <= 1'b1;
    end else if (read_end & (read_prev_rs == `DTMFHP_SEL_CTRL)) begin
      tx_done <= 1'b0;
    end
  end

  // Open-drain request or progress pin, and tone output
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      request_or_progress_out <= 1'b0;
      request_or_progress_oe <= 1'b0;
      tone_out_enable <= 1'b0;
      tone_out_code <= 4'h0;
    end else begin
      request_or_progress_out <= 1'b0;
      if (cp_mode) begin
        request_or_progress_oe <= ~progress_level;
      end else begin
        request_or_progress_oe <= control[`DTMFHP_CTL_IRQ_EN] & irq_level;
      end
      if (control[`DTMFHP_CTL_BURST]) begin
        tone_out_enable <= burst_tone & control[`DTMFHP_CTL_TONE_EN];
      end else begin
        tone_out_enable <= control[`DTMFHP_CTL_TONE_EN];
      end
      tone_out_code <= tx_code;
    end
  end

endmodule // dtmfhp_top

// ===== verification/dtmfhp_host_model.sv
// Purpose: Host model for the strobe port, driving at falling edges.
// Assumes: Select is already qualified by the host's address latch.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/100ps
module dtmfhp_host_model (
  // Clock
  input wire clk,
  // Strobes and data to the port
  output logic chip_select_n,
  output logic read_n,
  output logic write_n,
  output logic register_select,
  output logic [3:0] host_data_in,
  // Data from the port
  input wire [3:0] host_data_out,
  input wire host_data_oe
);
  // Idle: deselected, strobes high
  initial begin
    chip_select_n = 1'b1;
    read_n = 1'b1;
    write_n = 1'b1;
    register_select = 1'b0;
    host_data_in = 4'h0;
  end
  // Write: strobe low one cycle, then high with select held
  task wr(input logic rs, input logic [3:0] d);
    begin
      @(negedge clk);
      chip_select_n = 1'b0;
      register_select = rs;
      host_data_in = d;
      write_n = 1'b0;
      @(negedge clk);
      write_n = 1'b1;
      @(negedge clk);
      chip_select_n = 1'b1;
      host_data_in = ~d;
    end
  endtask
  // Read: data taken settled, half a cycle after the strobe is sampled
  task rd(input logic rs, output logic [3:0] d, output logic oe);
    begin
      @(negedge clk);
      chip_select_n = 1'b0;
      register_select = rs;
      read_n = 1'b0;
      @(posedge clk);
      @(negedge clk);
      d = host_data_out;
      oe = host_data_oe;
      read_n = 1'b1;
      chip_select_n = 1'b1;
    end
  endtask
endmodule // dtmfhp_host_model

// ===== verification/dtmfhp_props.sv
// Purpose: Port checks for the tone transceiver host port.
// Assumes: One clock domain, async active-low reset.
// Notes: Bound to the top module below.
`timescale 1ns/100ps
module dtmfhp_props (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Host strobes
  input wire chip_select_n,
  input wire read_n,
  // Detector and pin inputs
  input wire tone_pair_valid,
  input wire steering_guard_in,
  // Watched outputs
  input wire host_data_oe,
  input wire early_detect_out,
  input wire steering_guard_out,
  input wire steering_guard_oe,
  input wire request_or_progress_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_read_drive: assert property (!chip_select_n && !read_n |=> host_data_oe)
    else $error("data bus not driven on read");
  chk_read_release: assert property (read_n |=> !host_data_oe)
    else $error("data bus driven without read");
  chk_deselect_quiet: assert property (chip_select_n |=> !host_data_oe)
    else $error("data bus driven while deselected");
  chk_est_cause: assert property ($rose(early_detect_out) |-> $past(tone_pair_valid))
    else $error("early detect rose without tone pair");
  chk_est_loss: assert property (!tone_pair_valid |=> !early_detect_out)
    else $error("early detect held after signal loss");
  chk_guard_level: assert property (
    $past(reset_n) |-> steering_guard_out == $past(early_detect_out))
    else $error("guard level wrong");
  chk_guard_enable: assert property (
    $past(reset_n) |-> steering_guard_oe == ($past(early_detect_out) == $past(steering_guard_in)))
    else $error("guard enable wrong");
  chk_drain_low: assert property (request_or_progress_out == 1'b0)
    else $error("open drain pin driven high");
endmodule // dtmfhp_props
bind dtmfhp_top dtmfhp_props u_props (.clk(clk), .reset_n(reset_n),
  .chip_select_n(chip_select_n), .read_n(read_n), .tone_pair_valid(tone_pair_valid),
  .steering_guard_in(steering_guard_in), .host_data_oe(host_data_oe),
  .early_detect_out(early_detect_out), .steering_guard_out(steering_guard_out),
  .steering_guard_oe(steering_guard_oe), .request_or_progress_out(request_or_progress_out));

// ===== verification/test_dtmfhp_top.sv
// Purpose: Self-checking bench for the tone transceiver host port.
// Assumes: Burst and pause shortened to 8 cycles.
// Notes: Bench acts as detector and steering RC network.
`timescale 1ns/100ps
module test_dtmfhp_top;
  // Clock, reset and counters
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  int failures = 0;
  int checks_done = 0;
  // Detector side stimulus
  logic tone_pair_valid = 1'b0;
  logic [1:0] tone_low_index = 2'h0;
  logic [1:0] tone_high_index = 2'h0;
  logic progress_level = 1'b1;
  logic rc_level = 1'b0;
  logic [3:0] rdata;
  logic roe;
  // Port wires
  wire chip_select_n, read_n, write_n, register_select, host_data_oe;
  wire [3:0] host_data_in, host_data_out, tone_out_code;
  wire steering_guard_in, steering_guard_out, steering_guard_oe, early_detect_out;
  wire request_or_progress_out, request_or_progress_oe, tone_out_enable;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Steering pin: guard drive wins over the RC node
  assign steering_guard_in = steering_guard_oe ? steering_guard_out : rc_level;
  dtmfhp_top #(.BURST_CYC(22'h8), .PAUSE_CYC(22'h8)) dut (.clk(clk), .reset_n(reset_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
    .register_select(register_select), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .tone_pair_valid(tone_pair_valid), .tone_low_index(tone_low_index),
    .tone_high_index(tone_high_index), .progress_level(progress_level),
    .steering_guard_in(steering_guard_in), .steering_guard_out(steering_guard_out),
    .steering_guard_oe(steering_guard_oe), .early_detect_out(early_detect_out),
    .request_or_progress_out(request_or_progress_out),
    .request_or_progress_oe(request_or_progress_oe),
    .tone_out_enable(tone_out_enable), .tone_out_code(tone_out_code));
  dtmfhp_host_model u_host (.clk(clk), .chip_select_n(chip_select_n), .read_n(read_n),
    .write_n(write_n), .register_select(register_select), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  // Compare and count
  task chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task wrap_up;
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Code map, one nibble per row and column, lowest nibble first
  localparam logic [63:0] CODE_TABLE = 64'h0CABF987E654D321;
  // Expected receive code for a row and column
  function automatic logic [3:0] exp_code(input logic [1:0] l, input logic [1:0] h);
    return CODE_TABLE[{l, h, 2'h0} +: 4];
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // All sixteen pairs through steering, status and data read
  task test_rx;
    u_host.wr(1'b1, 4'h2);
    for (int p = 0; p < 16; p++) begin
      tone_low_index = p[3:2];
      tone_high_index = p[1:0];
      tone_pair_valid = 1'b1;
      cyc(2);
      chk("early detect", {3'h0, early_detect_out}, 4'h1);
      rc_level = 1'b1;
      cyc(8);
      chk("request pin", {3'h0, request_or_progress_oe}, 4'h1);
      u_host.rd(1'b1, rdata, roe);
      chk("status", rdata, 4'hD);
      u_host.rd(1'b0, rdata, roe);
      chk("rx code", rdata, exp_code(p[3:2], p[1:0]));
      chk("read drive", {3'h0, roe}, 4'h1);
      tone_pair_valid = 1'b0;
      rc_level = 1'b0;
      cyc(4);
      chk("early loss", {3'h0, early_detect_out}, 4'h0);
      u_host.rd(1'b1, rdata, roe);
      chk("status idle", rdata, 4'h0);
      chk("request idle", {3'h0, request_or_progress_oe}, 4'h0);
    end
    $display("test_rx done");
  endtask
  // Progress mode: pin follows comparator, no decoding
  task test_progress;
    u_host.wr(1'b1, 4'h4);
    tone_pair_valid = 1'b1;
    progress_level = 1'b0;
    cyc(3);
    chk("progress low", {3'h0, request_or_progress_oe}, 4'h1);
    chk("no decode", {3'h0, early_detect_out}, 4'h0);
    progress_level = 1'b1;
    cyc(3);
    chk("progress high", {3'h0, request_or_progress_oe}, 4'h0);
    tone_pair_valid = 1'b0;
    $display("test_progress done");
  endtask
  // Burst: tone length, done flag, request, clear on read
  task test_burst;
    int n;
    n = 0;
    u_host.wr(1'b1, 4'hB);
    u_host.wr(1'b0, 4'h5);
    repeat (4) if (tone_out_enable !== 1'b1) cyc(1);
    chk("tone code", tone_out_code, 4'h5);
    while (tone_out_enable === 1'b1 && n < 15) begin
      cyc(1);
      n++;
    end
    chk("burst length", n[3:0], 4'h8);
    cyc(12);
    chk("tx request", {3'h0, request_or_progress_oe}, 4'h1);
    u_host.rd(1'b1, rdata, roe);
    chk("tx done", rdata, 4'h3);
    u_host.rd(1'b1, rdata, roe);
    chk("tx cleared", rdata, 4'h0);
    chk("tx request off", {3'h0, request_or_progress_oe}, 4'h0);
    // Plain tone enable without burst timing
    u_host.wr(1'b1, 4'h1);
    cyc(2);
    chk("steady tone", {3'h0, tone_out_enable}, 4'h1);
    chk("steady code", tone_out_code, 4'h5);
    $display("test_burst done");
  endtask
  // Main sequence
  initial begin
    cyc(12);
    reset_n = 1'b1;
    chk("reset pin", {3'h0, request_or_progress_oe}, 4'h0);
    test_rx;
    test_progress;
    test_burst;
    wrap_up;
  end
  // Watchdog
  initial begin
    #(25 * 4000);
    failures++;
    wrap_up;
  end
endmodule // test_dtmfhp_top
